// *** port_mode_pkg.sv ***
`default_nettype none
package port_mode_pkg;
   // =====================================================
   // register map (byte addresses, one word each)
   localparam logic [11:0] OFF_INPUT_MODE = 12'h000;
   localparam logic [11:0] OFF_OUTPUT_MODE = 12'h004;
   localparam logic [11:0] OFF_LATCH = 12'h008;
   localparam logic [11:0] OFF_GLOBAL_CTRL = 12'h00C;
   localparam logic [11:0] OFF_PAD_READ = 12'h010;
   localparam logic [11:0] OFF_PERIPH_SEL = 12'h014;
   // =====================================================
   // field positions
   localparam int CTRL_XBAR_BIT = 0;
   localparam int CTRL_PUD_BIT = 1;
   localparam int PORT2_BIT = 16;
   // =====================================================
   // reset values
   localparam logic [15:0] RST_INPUT_MODE = 16'hFFFF;
   localparam logic [16:0] RST_OUTPUT_MODE = 17'h00000;
   localparam logic [16:0] RST_LATCH = 17'h1FFFF;
   localparam logic [1:0] RST_GLOBAL_CTRL = 2'h0;
   localparam logic [16:0] RST_PERIPH_SEL = 17'h00000;
   // =====================================================
   // per-pin pad controls
   typedef struct packed {
      logic [16:0] drive_high;
      logic [16:0] drive_low;
      logic [16:0] pullup_on;
      logic [16:0] receiver_on;
   } pad_ctrl_t;
endpackage : port_mode_pkg
`default_nettype wire

// *** port_pad_model.sv ***
`default_nettype none
module port_pad_model (
   // clock
   input wire logic pclk,
   // cell side
   input wire logic [16:0] pad_out,
   input wire logic [16:0] pad_oe,
   input wire logic [16:0] pad_pullup,
   // board side
   input wire logic [16:0] ext_en,
   input wire logic [16:0] ext_val,
   output logic [16:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [16:0] noise_r = 17'h0AAAA;
   // floating pads wander each cycle, so no stale level can pass for a real one
   always @(posedge pclk) noise_r <= ~noise_r;
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pullup | noise_r));
endmodule // port_pad_model
`default_nettype wire

// *** port_pin_mode_control.sv ***
`default_nettype none
// Behaviour
// - pins 0..15 select analog or digital by input-mode bit, with output-mode bit
// - pin 16 is digital only, configured solely by its output-mode bit
// - after reset every pin is high impedance with weak pull-up on
// - crossbar disabled keeps both drivers off on all crossbar pins
// - analog pin disables pull-up, output driver and input receiver
// - analog pin always reads back zero
// - input-mode one makes pin digital; output-mode picks push-pull or open-drain
// - push-pull drives pad high or low from output value
// - open-drain never drives high; low on zero, released on one
// - digital pull-up on when cell released, off when driving low
// - global pull-up disable turns off all weak pull-ups
// - digital pin reads the sensed pad level
module port_pin_mode_control
   import port_mode_pkg::*;
#(
   parameter int NPINS = 17
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // peripheral side, from crossbar
   input wire logic [NPINS-1:0] periph_assign,
   input wire logic [NPINS-1:0] periph_out,
   // pads
   input wire logic [NPINS-1:0] pad_in,
   output logic [NPINS-1:0] pad_out,
   output logic [NPINS-1:0] pad_oe,
   output logic [NPINS-1:0] pad_pullup,
   output logic [NPINS-1:0] pad_analog,
   output logic [NPINS-1:0] pin_read
);
   // =====================================================
   // register state
   logic [15:0] pin_input_mode_bits_r, pin_input_mode_bits_nxt;
   logic [16:0] pin_output_mode_bits_r, pin_output_mode_bits_nxt;
   logic [16:0] port_latch_bit_r, port_latch_bit_nxt;
   logic crossbar_enable_bit_r, crossbar_enable_bit_nxt;
   logic pullup_global_disable_r, pullup_global_disable_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [16:0] pad_sense_r, pad_sense_nxt;
   logic [16:0] digital;
   logic [16:0] out_val;
   logic wr_en, rd_en, addr_ok;
   pad_ctrl_t pc;

   // single-cycle access phase: no wait states
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   // read data is registered at the setup edge, so it already stands when the access edge samples it
   assign rd_en = psel & ~penable & ~pwrite;
   assign addr_ok = (paddr == OFF_INPUT_MODE) | (paddr == OFF_OUTPUT_MODE) | (paddr == OFF_LATCH) |
                    (paddr == OFF_GLOBAL_CTRL) | (paddr == OFF_PAD_READ) | (paddr == OFF_PERIPH_SEL);

   // =====================================================
   // pin mode decode
   // per-pin analog select
   assign digital = {1'b1, pin_input_mode_bits_r};
   assign out_val = (periph_assign & periph_out) | (~periph_assign & port_latch_bit_r);

   // pad cell controls per pin
   always_comb begin
      pc = '0;
      for (int i = 0; i < NPINS; i++) begin
         if (digital[i] && crossbar_enable_bit_r) begin
            pc.drive_high[i] = pin_output_mode_bits_r[i] & out_val[i];
            pc.drive_low[i] = ~out_val[i];
         end
         pc.receiver_on[i] = digital[i];
         // released cell keeps pull-up after reset
         pc.pullup_on[i] = digital[i] & ~pc.drive_low[i] & ~pullup_global_disable_r;
      end
   end

   // pad sampling and readback
   always_comb begin
      pad_sense_nxt = pad_in & pc.receiver_on;
   end

   // =====================================================
   // register writes and reads
   always_comb begin
      pin_input_mode_bits_nxt = pin_input_mode_bits_r;
      pin_output_mode_bits_nxt = pin_output_mode_bits_r;
      port_latch_bit_nxt = port_latch_bit_r;
      crossbar_enable_bit_nxt = crossbar_enable_bit_r;
      pullup_global_disable_nxt = pullup_global_disable_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      if (psel && !penable) begin
         // setup phase decides the error answer ahead of access
         pslverr_nxt = ~addr_ok;
      end
      if (wr_en && addr_ok) begin
         unique case (paddr)
            OFF_INPUT_MODE: begin
               if (pstrb[0]) pin_input_mode_bits_nxt[7:0] = pwdata[7:0];
               if (pstrb[1]) pin_input_mode_bits_nxt[15:8] = pwdata[15:8];
            end
            OFF_OUTPUT_MODE: begin
               if (pstrb[0]) pin_output_mode_bits_nxt[7:0] = pwdata[7:0];
               if (pstrb[1]) pin_output_mode_bits_nxt[15:8] = pwdata[15:8];
               if (pstrb[2]) pin_output_mode_bits_nxt[PORT2_BIT] = pwdata[PORT2_BIT];
            end
            OFF_LATCH: begin
               // latch bits feed the output value of every pin not assigned to a peripheral
               if (pstrb[0]) port_latch_bit_nxt[7:0] = pwdata[7:0];
               if (pstrb[1]) port_latch_bit_nxt[15:8] = pwdata[15:8];
               if (pstrb[2]) port_latch_bit_nxt[PORT2_BIT] = pwdata[PORT2_BIT];
            end
            OFF_GLOBAL_CTRL: begin
               if (pstrb[0]) begin
                  crossbar_enable_bit_nxt = pwdata[CTRL_XBAR_BIT];
                  pullup_global_disable_nxt = pwdata[CTRL_PUD_BIT];
               end
            end
            default: begin
            end
         endcase
      end
      if (rd_en) begin
         unique case (paddr)
            OFF_INPUT_MODE: prdata_nxt = {16'h0000, pin_input_mode_bits_r};
            OFF_OUTPUT_MODE: prdata_nxt = {15'h0000, pin_output_mode_bits_r};
            OFF_LATCH: prdata_nxt = {15'h0000, port_latch_bit_r};
            OFF_GLOBAL_CTRL: prdata_nxt = {30'h00000000, pullup_global_disable_r, crossbar_enable_bit_r};
            OFF_PAD_READ: prdata_nxt = {15'h0000, pad_sense_r};
            OFF_PERIPH_SEL: prdata_nxt = {15'h0000, periph_assign};
            default: prdata_nxt = 32'h00000000;
         endcase
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_input_mode_bits_r <= RST_INPUT_MODE;
         pin_output_mode_bits_r <= RST_OUTPUT_MODE;
         port_latch_bit_r <= RST_LATCH;
         crossbar_enable_bit_r <= RST_GLOBAL_CTRL[CTRL_XBAR_BIT];
         pullup_global_disable_r <= RST_GLOBAL_CTRL[CTRL_PUD_BIT];
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
         pad_sense_r <= 17'h00000;
      end else begin
         pin_input_mode_bits_r <= pin_input_mode_bits_nxt;
         pin_output_mode_bits_r <= pin_output_mode_bits_nxt;
         port_latch_bit_r <= port_latch_bit_nxt;
         crossbar_enable_bit_r <= crossbar_enable_bit_nxt;
         pullup_global_disable_r <= pullup_global_disable_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         pad_sense_r <= pad_sense_nxt;
      end
   end

   // =====================================================
   // outputs; pad controls combinational so reset shows released pads
   assign prdata = prdata_r;
   assign pslverr = pslverr_r & psel & penable;
   assign pad_out = pc.drive_high;
   assign pad_oe = pc.drive_high | pc.drive_low;
   assign pad_pullup = pc.pullup_on;
   assign pad_analog = ~digital;
   assign pin_read = pad_sense_r;
endmodule : port_pin_mode_control
`default_nettype wire

// *** port_pin_mode_control_sva.sv ***
`default_nettype none
module port_pin_mode_control_sva
   import port_mode_pkg::*;
#(
   parameter int NPINS = 17
) (
   // clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   // pads
   input wire logic [NPINS-1:0] pad_in,
   input wire logic [NPINS-1:0] pad_out,
   input wire logic [NPINS-1:0] pad_oe,
   input wire logic [NPINS-1:0] pad_pullup,
   input wire logic [NPINS-1:0] pad_analog,
   input wire logic [NPINS-1:0] pin_read
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ctrl_r;
   logic [1:0] ctrl_nxt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========
   // shadow of the control word, seen only through bus writes
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (psel && penable && pwrite && paddr == OFF_GLOBAL_CTRL && pstrb[0]) ctrl_nxt = pwdata[1:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_r <= RST_GLOBAL_CTRL;
      else ctrl_r <= ctrl_nxt;
   end
   // ==========
   reset_idle_a: assert property ($rose(presetn) |-> pad_oe == '0 && pad_pullup == '1)
      else $error("pads not idle after reset");
   xbar_off_a: assert property (!ctrl_r[CTRL_XBAR_BIT] |-> pad_oe == '0)
      else $error("pad driven with crossbar off");
   analog_off_a: assert property (pad_analog != '0 |-> (pad_analog & (pad_oe | pad_pullup)) == '0)
      else $error("analog pin still driven or pulled");
   read_path_a: assert property ($past(presetn) |-> pin_read == ($past(pad_in) & ~$past(pad_analog)))
      else $error("pin read not pad level");
   low_drive_pu_a: assert property ((pad_oe & ~pad_out) != '0 |-> (pad_oe & ~pad_out & pad_pullup) == '0)
      else $error("pull-up on while driving low");
   released_pu_a: assert property (!ctrl_r[CTRL_PUD_BIT] |-> (~pad_oe & ~pad_analog & ~pad_pullup) == '0)
      else $error("released pin without pull-up");
   pud_off_a: assert property (ctrl_r[CTRL_PUD_BIT] |-> pad_pullup == '0)
      else $error("pull-up on despite global disable");
   pin16_digital_a: assert property (pad_analog[NPINS-1] == 1'b0)
      else $error("last pin went analog");
   cover property (pad_analog != '0);
   cover property (ctrl_r[CTRL_XBAR_BIT] && pad_oe != '0);
   cover property (ctrl_r[CTRL_PUD_BIT]);
endmodule // port_pin_mode_control_sva
bind port_pin_mode_control port_pin_mode_control_sva #(.NPINS(NPINS)) chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_analog(pad_analog),
   .pin_read(pin_read));
`default_nettype wire

// *** port_pin_mode_control_test.sv ***
`default_nettype none
module port_pin_mode_control_test
   import port_mode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   // pa/po: crossbar assignment and peripheral value, en/ev: board drive
   logic [16:0] pa = '0, po = '0, en = '0, ev = '0, pad_in, pad_out, pad_oe, pad_pullup, pad_analog, pin_read;
   int mismatches = 0, total_checks = 0;
   port_pin_mode_control #(.NPINS(17)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_assign(pa), .periph_out(po), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_analog(pad_analog), .pin_read(pin_read));
   port_pad_model board (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
      .ext_en(en), .ext_val(ev), .pad_in(pad_in));
   always #5 pclk = ~pclk;
   // ==========
   task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // one transfer; read data and error taken at the edge that sees pready, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      ck(n, e, q);
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, far beyond the 64 cycles the sequence needs
   initial begin
      #100us;
      mismatches++;
      tally_and_finish();
   end
   // ==========
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      ck("oe_rst", 32'h0, pad_oe);
      ck("pu_rst", 32'h1FFFF, pad_pullup);
      rc("in_mode", OFF_INPUT_MODE, 32'h0000FFFF);
      rc("out_mode", OFF_OUTPUT_MODE, 32'h0);
      rc("latch", OFF_LATCH, 32'h0001FFFF);
      rc("ctrl", OFF_GLOBAL_CTRL, 32'h0);
      rc("hole", 12'h0F0, 32'h0);
      ck("hole_err", 32'h1, err);
      apb(1'b1, OFF_LATCH, 32'h0001A5C3);
      apb(1'b1, OFF_OUTPUT_MODE, 32'h0001FFFF);
      ck("oe_xoff", 32'h0, pad_oe);
      apb(1'b1, OFF_GLOBAL_CTRL, 32'h1);
      ck("oe_pp", 32'h1FFFF, pad_oe);
      ck("out_pp", 32'h1A5C3, pad_out);
      rc("rd_pp", OFF_PAD_READ, 32'h1A5C3);
      pa <= 17'h000F0;
      po <= 17'h00050;
      en <= 17'h0000F;
      @(posedge pclk);
      ck("out_per", 32'h1A553, pad_out);
      rc("per_sel", OFF_PERIPH_SEL, 32'h000F0);
      apb(1'b1, OFF_OUTPUT_MODE, 32'h0);
      ck("oe_od", 32'h05AAC, pad_oe);
      ck("pu_od", 32'h1A553, pad_pullup);
      rc("rd_od", OFF_PAD_READ, 32'h1A550);
      apb(1'b1, OFF_GLOBAL_CTRL, 32'h3);
      ck("pu_dis", 32'h0, pad_pullup);
      apb(1'b1, OFF_GLOBAL_CTRL, 32'h1);
      apb(1'b1, OFF_LATCH, 32'h0001A5FF);
      apb(1'b1, OFF_INPUT_MODE, 32'h0001FF00);
      rc("in_p2", OFF_INPUT_MODE, 32'h0000FF00);
      ck("ana", 32'h000FF, pad_analog);
      ck("ana_oe", 32'h0, pad_oe & 17'h000FF);
      ck("ana_pu", 32'h0, pad_pullup & 17'h000FF);
      en <= 17'h1FFFF;
      ev <= 17'h1FFFF;
      @(posedge pclk);
      rc("rd_ana", OFF_PAD_READ, 32'h1A500);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      ck("oe_rst2", 32'h0, pad_oe);
      ck("pu_rst2", 32'h1FFFF, pad_pullup);
      tally_and_finish();
   end
endmodule // port_pin_mode_control_test
`default_nettype wire
